/* File: common/iofm_consts.svh */
`ifndef IOFM_CONSTS_SVH
`define IOFM_CONSTS_SVH

// ==========================================================
// Register byte addresses (index times four)
`define IOFM_IDX_PWE        8'h18
`define IOFM_IDX_ABI        8'h19
`define IOFM_IDX_MSK        8'h1a
`define IOFM_ADDR_PWE       8'h60
`define IOFM_ADDR_ABI       8'h64
`define IOFM_ADDR_MSK       8'h68
`define IOFM_ADDR_CTL       8'h80
`define IOFM_ADDR_STS       8'h84

// ==========================================================
// Reset values
`define IOFM_RST_PWE        24'h000000
`define IOFM_RST_ABI        24'h000000
`define IOFM_RST_MSK        24'h000000
`define IOFM_RST_CTL        3'h0

// ==========================================================
// Field positions
`define IOFM_PWE_TR         11
`define IOFM_PWE_TOV        12
`define IOFM_PWE_OFS_HI     23
`define IOFM_PWE_OFS_LO     13
`define IOFM_ABI_RES_HI     3
`define IOFM_ABI_UVW        4
`define IOFM_ABI_IOE        5
`define IOFM_ABI_PLH        6
`define IOFM_ABI_WDH        7
`define IOFM_ABI_IDX_HI     9
`define IOFM_ABI_IDX_LO     8
`define IOFM_ABI_AHE        12
`define IOFM_ABI_INV        15
`define IOFM_ABI_SLEW_HI    21
`define IOFM_ABI_SLEW_LO    16
`define IOFM_MSK_WARN       11
`define IOFM_CTL_PEO        0
`define IOFM_CTL_PES        1
`define IOFM_CTL_TCP        2
`define IOFM_MASKABLE       24'hdff7ff
`define IOFM_WARNINGS       24'h118000

// ==========================================================
// PWM error duty in 1/1600 steps, timing
`define IOFM_DUTY_BASE      11'd80
`define IOFM_DUTY_STEP      11'd90
`define IOFM_CLK_PERIOD_NS  50
`define IOFM_SLEW_UNIT_NS   125
`define IOFM_MAX_RES_CODE   4'd14

`endif

/* File: common/iofm_pkg.sv */
package iofm_pkg;

    typedef struct packed {
        logic [23:0] pwm_error_enables_and_turns_align;
        logic [23:0] abi;
        logic [23:0] msk;
        logic [2:0]  ctl;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
        logic [2:0]  q_raw;
        logic [2:0]  inc_out;
        logic [2:0]  inc_oe_n;
        logic [7:0]  slew_cnt;
        logic        agg;
        logic        caution;
        logic [11:0] turns;
        logic        pwm_half;
        logic [3:0]  pwm_code;
        logic [10:0] pwm_duty;
    } iofm_state_s;

endpackage

/* File: hdl/iofm_top.sv */
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`include "iofm_consts.svh"
// Overview of operation
// - Temperature error reports 66.875% duty, half frequency
// - Turns overflow reports 72.5% duty, half frequency
// - Offset added to zero-crossing angle for turns
// - Misalignment over 180 degrees tolerated, not corrected
// - Quadrature gives 2^(14-n) cycles per turn
// - Commutation code is pole pairs minus one
// - Output-type bit selects commutation or quadrature
// - Incremental pins driven only when enabled
// - PLL unlock forces quadrature high before inversion
// - Watchdog trip forces quadrature high before inversion
// - Index mode sets index pulse width, placement
// - Hysteresis bit selects filtered angle for outputs
// - Polarity bit inverts incremental outputs
// - Slew code sets minimum A/B edge spacing in quadrature mode only
// - Mask bits 0-10 exclude errors from flag
// - Mask bits 12-20,22,23 exclude errors from flag
// - Warning mask suppresses caution summary bit
// - Duty mode halves carrier, reports top error
// - Turns follow PLL unless low power or unlocked
module iofm_top
    import iofm_pkg::*;
(
    input  wire logic        hclk,          // System clock
    input  wire logic        hresetn,       // Async reset, active low
    input  wire logic        hsel,          // Slave select
    input  wire logic [31:0] haddr,         // Byte address
    input  wire logic [1:0]  htrans,        // Transfer type
    input  wire logic        hwrite,        // Write strobe
    input  wire logic [2:0]  hsize,         // Transfer size
    input  wire logic [31:0] hwdata,        // Write data
    input  wire logic        hready,        // Bus ready in
    output logic      [31:0] hrdata,        // Read data
    output logic             hreadyout,     // Ready out
    output logic             hresp,         // Always OKAY
    input  wire logic [15:0] angle_raw,     // Unfiltered angle
    input  wire logic [15:0] angle_hys,     // Hysteresis angle
    input  wire logic [11:0] zcd_angle,     // Zero-crossing angle
    input  wire logic [11:0] pll_angle,     // PLL angle
    input  wire logic        pll_locked,    // PLL lock
    input  wire logic        low_power,     // Low-power mode
    input  wire logic        hf_wdog_trip,  // Watchdog trip
    input  wire logic [23:0] err_active,    // Errors, mask order
    input  wire logic [12:0] pwm_err_src,   // Errors, enable order
    output logic      [2:0]  inc_out,       // I/A/B or U/V/W
    output logic      [2:0]  inc_oe_n,      // Pin enable, low drives
    output logic             aggregate_error_flag, // Unmasked error
    output logic             caution_summary_bit,  // Unmasked warning
    output logic      [11:0] turns_angle,   // Angle for turns
    output logic             pwm_half_freq, // Halve carrier
    output logic      [3:0]  pwm_err_code,  // Reported error, 0 none
    output logic      [10:0] pwm_err_duty   // Duty, 1/1600 units
);

    iofm_state_s s;
    iofm_state_s n;

    // ==========================================================
    // Helper functions

    // Slew hold in whole clock cycles, rounded up
    function automatic logic [7:0] slew_cycles(input logic [5:0] code);
        int ns;
        ns = (int'(code) + 1) * `IOFM_SLEW_UNIT_NS;
        return 8'((ns + `IOFM_CLK_PERIOD_NS - 1) / `IOFM_CLK_PERIOD_NS);
    endfunction

    // Register map read; unmapped offsets return zero
    function automatic logic [31:0] reg_read(input logic [7:0] a, input iofm_state_s st);
        logic [31:0] v;
        v = 32'h00000000;
        case (a)
            `IOFM_ADDR_PWE: v = {8'h00, st.pwm_error_enables_and_turns_align};
            `IOFM_ADDR_ABI: v = {8'h00, st.abi};
            `IOFM_ADDR_MSK: v = {8'h00, st.msk};
            `IOFM_ADDR_CTL: v = {29'h00000000, st.ctl};
            `IOFM_ADDR_STS: v = {8'h00, st.turns, 1'b0, st.inc_out, (st.slew_cnt != 8'h00),
                                 st.pwm_half, st.pwm_code, st.caution, st.agg};
            default:        v = 32'h00000000;
        endcase
        return v;
    endfunction

    // ==========================================================
    // Next-state logic
    logic        force_c;
    logic        agg_c;
    logic [15:0] ang_c;
    logic [3:0]  res_c;
    logic [2:0]  tgt_c;

    always_comb begin
        logic [15:0] step;
        logic [15:0] wmask;
        logic [15:0] elec;
        logic [18:0] sect;
        logic        idx;
        logic        hit;
        logic [3:0]  pick;
        n = s;
        step = 16'h0000;
        wmask = 16'h0000;
        elec = 16'h0000;
        sect = 19'h00000;
        idx = 1'b0;
        hit = 1'b0;
        pick = 4'h0;

        // Register writes in the data phase
        if (s.wr_pend) begin
            case (s.wr_addr)
                `IOFM_ADDR_PWE: n.pwm_error_enables_and_turns_align = hwdata[23:0];
                `IOFM_ADDR_ABI: n.abi = hwdata[23:0];
                `IOFM_ADDR_MSK: n.msk = hwdata[23:0];
                `IOFM_ADDR_CTL: n.ctl = hwdata[2:0];
                default: ;
            endcase
        end
        n.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            n.wr_pend = hwrite;
            n.wr_addr = haddr[7:0];
        end

        // Error flag and caution summary
        agg_c = |(err_active & ~s.msk & `IOFM_MASKABLE);
        n.agg = agg_c;
        n.caution = !s.msk[`IOFM_MSK_WARN] && |(err_active & ~s.msk & `IOFM_WARNINGS);

        // Turns angle; misalignment over half a turn is left to software
        if (s.ctl[`IOFM_CTL_TCP] && pll_locked && !low_power) begin
            n.turns = pll_angle;
        end else begin
            n.turns = zcd_angle + {s.pwm_error_enables_and_turns_align[`IOFM_PWE_OFS_HI:`IOFM_PWE_OFS_LO], 1'b0};
        end

        // PWM error report, lowest enable position has priority
        for (int i = 12; i >= 0; i--) begin
            if (s.pwm_error_enables_and_turns_align[i] && pwm_err_src[i]) begin
                hit = 1'b1;
                pick = 4'(i);
            end
        end
        if (s.ctl[`IOFM_CTL_PEO] && s.ctl[`IOFM_CTL_PES] && hit) begin
            n.pwm_half = 1'b1;
            n.pwm_code = pick + 4'h1;
            n.pwm_duty = `IOFM_DUTY_BASE + 11'(pick) * `IOFM_DUTY_STEP;
        end else begin
            n.pwm_half = 1'b0;
            n.pwm_code = 4'h0;
            n.pwm_duty = 11'h000;
        end

        // Incremental pattern
        ang_c = s.abi[`IOFM_ABI_AHE] ? angle_hys : angle_raw;
        res_c = s.abi[`IOFM_ABI_RES_HI:0];
        force_c = (s.abi[`IOFM_ABI_PLH] && !pll_locked) || (s.abi[`IOFM_ABI_WDH] && hf_wdog_trip);
        if (s.abi[`IOFM_ABI_UVW]) begin
            elec = 16'(ang_c * ({1'b0, res_c} + 5'h01));
            sect = 19'(elec * 3'h6);
            case (sect[18:16])
                3'h0:    tgt_c = 3'b100;
                3'h1:    tgt_c = 3'b110;
                3'h2:    tgt_c = 3'b010;
                3'h3:    tgt_c = 3'b011;
                3'h4:    tgt_c = 3'b001;
                default: tgt_c = 3'b101;
            endcase
        end else begin
            if (res_c > `IOFM_MAX_RES_CODE) begin
                res_c = `IOFM_MAX_RES_CODE;
            end
            step = ang_c >> res_c;
            wmask = 16'hffff >> res_c;
            case (s.abi[`IOFM_ABI_IDX_HI:`IOFM_ABI_IDX_LO])
                2'h0:    idx = (step == 16'h0000);
                2'h1:    idx = (step == 16'h0000) || (step == wmask);
                2'h2:    idx = (step == 16'h0000) || (step == wmask) || (step == 16'h0001);
                default: idx = (step == 16'h0000) || (step == wmask) || (step == 16'h0001)
                               || (step == wmask - 16'h0001);
            endcase
            tgt_c = {idx, step[1], step[1] ^ step[0]};
            if (force_c) begin
                tgt_c = 3'b111;
            end
        end
        if (s.abi[`IOFM_ABI_UVW]) begin
            n.q_raw = tgt_c;
            n.slew_cnt = 8'h00;
        end else if (s.slew_cnt != 8'h00) begin
            n.slew_cnt = s.slew_cnt - 8'h01;
        end else begin
            n.q_raw = tgt_c;
            if (s.abi[`IOFM_ABI_SLEW_HI:`IOFM_ABI_SLEW_LO] != 6'h00 && tgt_c[1:0] != s.q_raw[1:0]) begin
                n.slew_cnt = slew_cycles(s.abi[`IOFM_ABI_SLEW_HI:`IOFM_ABI_SLEW_LO]) - 8'h01;
            end
        end
        n.inc_out = n.q_raw ^ {3{s.abi[`IOFM_ABI_INV]}};
        n.inc_oe_n = {3{!s.abi[`IOFM_ABI_IOE]}};

        // Read data, with the current write already visible
        n.rdata = 32'h00000000;
        if (hsel && htrans[1] && hready && !hwrite) begin
            n.rdata = reg_read(haddr[7:0], n);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.pwm_error_enables_and_turns_align <= `IOFM_RST_PWE;
            s.abi <= `IOFM_RST_ABI;
            s.msk <= `IOFM_RST_MSK;
            s.ctl <= `IOFM_RST_CTL;
            s.inc_oe_n <= 3'b111;
        end else begin
            s <= n;
        end
    end

    // ==========================================================
    // Outputs
    assign hrdata = s.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign inc_out = s.inc_out;
    assign inc_oe_n = s.inc_oe_n;
    assign aggregate_error_flag = s.agg;
    assign caution_summary_bit = s.caution;
    assign turns_angle = s.turns;
    assign pwm_half_freq = s.pwm_half;
    assign pwm_err_code = s.pwm_code;
    assign pwm_err_duty = s.pwm_duty;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_duty_mode;
        s.ctl[`IOFM_CTL_PEO] && s.ctl[`IOFM_CTL_PES];
    endsequence

    sequence s_quad_forced;
        !s.abi[`IOFM_ABI_UVW] && s.slew_cnt == 8'h00 && $stable(s.abi)
        && ((s.abi[`IOFM_ABI_PLH] && !pll_locked) || (s.abi[`IOFM_ABI_WDH] && hf_wdog_trip));
    endsequence

    sequence s_ab_edge_limited;
        !s.abi[`IOFM_ABI_UVW] && s.abi[`IOFM_ABI_SLEW_HI:`IOFM_ABI_SLEW_LO] != 6'h00
        && $changed(s.q_raw[1:0]) && $stable(s.abi);
    endsequence

    AST_TEMP_DUTY: assert property (s_duty_mode ##0 (s.pwm_error_enables_and_turns_align[11:0] & pwm_err_src[11:0]) == 12'h800
        |=> pwm_err_duty == 11'd1070 && pwm_err_code == 4'hc && pwm_half_freq)
        else $error("temperature duty code wrong");

    AST_TURNS_DUTY: assert property (s_duty_mode ##0 (s.pwm_error_enables_and_turns_align[12:0] & pwm_err_src) == 13'h1000
        |=> pwm_err_duty == 11'd1160 && pwm_err_code == 4'hd)
        else $error("turns overflow duty code wrong");

    AST_NO_REPORT: assert property (!s.ctl[`IOFM_CTL_PES] |=> !pwm_half_freq && pwm_err_code == 4'h0)
        else $error("error reported outside duty mode");

    AST_TURNS_ZCD: assert property (!s.ctl[`IOFM_CTL_TCP]
        |=> turns_angle == 12'($past(zcd_angle) + {$past(s.pwm_error_enables_and_turns_align[23:13]), 1'b0}))
        else $error("turns angle offset wrong");

    AST_TURNS_PLL: assert property (s.ctl[`IOFM_CTL_TCP] && pll_locked && !low_power
        |=> turns_angle == $past(pll_angle))
        else $error("turns angle not following pll");

    AST_PIN_ENABLE: assert property (!s.abi[`IOFM_ABI_IOE] |=> inc_oe_n == 3'b111 ##1 1)
        else $error("pins driven while disabled");

    AST_FORCE_HIGH: assert property (s_quad_forced |=> inc_out == ~{3{$past(s.abi[15])}})
        else $error("forced level wrong");

    AST_SLEW_SPACING: assert property (s_ab_edge_limited
        |=> (s.abi[`IOFM_ABI_UVW] || $stable(s.q_raw[1:0])) [*4])
        else $error("quadrature edges too close");

    AST_UVW_PATTERN: assert property (s.abi[`IOFM_ABI_UVW] |=> s.q_raw != 3'b000 && s.q_raw != 3'b111)
        else $error("invalid commutation pattern");

    AST_AGG_FLAG: assert property ((err_active & ~s.msk & `IOFM_MASKABLE) == 24'h000000
        ##1 (err_active & ~s.msk & `IOFM_MASKABLE) != 24'h000000 |-> !aggregate_error_flag ##1 aggregate_error_flag)
        else $error("aggregate flag timing wrong");

    AST_CAUTION_MASK: assert property (s.msk[`IOFM_MSK_WARN] |=> !caution_summary_bit)
        else $error("caution bit set while masked");

    // ==========================================================
    // Error flag and warning checks

    AST_AGG_QUIET: assert property ((err_active & ~s.msk & `IOFM_MASKABLE) == 24'h000000
        |=> !aggregate_error_flag)
        else $error("aggregate flag set with all errors masked");

    AST_CAUTION_SET: assert property (!s.msk[`IOFM_MSK_WARN] && (err_active & ~s.msk & `IOFM_WARNINGS) != 0
        |=> caution_summary_bit)
        else $error("caution bit missing for unmasked warning");

    // ==========================================================
    // Turns and PWM report checks

    sequence s_turns_fallback;
        s.ctl[`IOFM_CTL_TCP] && (!pll_locked || low_power);
    endsequence

    AST_TURNS_FALLBACK: assert property (s_turns_fallback
        |=> turns_angle == 12'($past(zcd_angle) + {$past(s.pwm_error_enables_and_turns_align[23:13]), 1'b0}))
        else $error("turns angle fallback wrong");

    AST_PWM_IDLE: assert property (s_duty_mode ##0 (s.pwm_error_enables_and_turns_align[12:0] & pwm_err_src) == 13'h0000
        |=> pwm_err_code == 4'h0 && pwm_err_duty == 11'h000 && !pwm_half_freq)
        else $error("error reported with no enabled error");

    AST_PWM_OFF: assert property (!s.ctl[`IOFM_CTL_PEO] |=> !pwm_half_freq)
        else $error("carrier halved with error output off");

    // ==========================================================
    // Pin and bus checks

    AST_PIN_DRIVE: assert property (s.abi[`IOFM_ABI_IOE] |=> inc_oe_n == 3'b000)
        else $error("pins not driven while enabled");

    AST_POLARITY: assert property (1'b1 |=> inc_out == (s.q_raw ^ {3{$past(s.abi[`IOFM_ABI_INV])}}))
        else $error("output polarity wrong");

    AST_UVW_NO_SLEW: assert property (s.abi[`IOFM_ABI_UVW] |=> s.slew_cnt == 8'h00)
        else $error("slew hold active in commutation mode");

    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus response not ready and okay");

    AST_RDATA_IDLE: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h00000000)
        else $error("read data outside read data phase");

endmodule

/* File: verification/iofm_ctrl_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Quadrature decoder on the incremental pins
module iofm_ctrl_model (
    input  wire logic       hclk,     // System clock
    input  wire logic       clr,      // Restart counts
    input  wire logic [2:0] inc_out,  // Incremental pins
    input  wire logic [2:0] inc_oe_n, // Pin enables
    output int              a_edges,  // A transitions seen
    output int              min_gap   // Shortest A/B spacing
);
    logic [1:0] ab_q;
    int         gap;

    // Only driven pins count as decoder input
    always @(posedge hclk) begin
        ab_q <= inc_out[1:0];
        if (clr) begin
            a_edges <= 0;
            min_gap <= 1000;
            gap     <= 1000;
        end else if (inc_oe_n === 3'b000) begin
            gap <= gap + 1;
            if (inc_out[1:0] !== ab_q) begin
                gap <= 1;
                if (gap < min_gap)
                    min_gap <= gap;
            end
            if (inc_out[1] !== ab_q[1])
                a_edges <= a_edges + 1;
        end
    end
endmodule

/* File: verification/iofm_top_tb_top.sv */
`timescale 1ns/1ps
`include "iofm_consts.svh"
module iofm_top_tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clr = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [15:0] angle_raw = '0, angle_hys = '0;
    logic [11:0] zcd_angle = '0, pll_angle = '0, turns_angle;
    logic        pll_locked = 1'b1, low_power = 1'b0, hf_wdog_trip = 1'b0;
    logic [23:0] err_active = '0;
    logic [12:0] pwm_err_src = '0;
    logic [2:0]  inc_out, inc_oe_n;
    logic        hreadyout, hresp, agg, caut, half;
    logic [3:0]  code;
    logic [10:0] duty;
    int          num_errors = 0, check_count = 0, a_edges, min_gap;
    logic [31:0] rd;

    always #25 hclk = ~hclk;

    iofm_top iofm_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .angle_raw(angle_raw), .angle_hys(angle_hys),
        .zcd_angle(zcd_angle), .pll_angle(pll_angle), .pll_locked(pll_locked), .low_power(low_power),
        .hf_wdog_trip(hf_wdog_trip), .err_active(err_active), .pwm_err_src(pwm_err_src),
        .inc_out(inc_out), .inc_oe_n(inc_oe_n), .aggregate_error_flag(agg), .caution_summary_bit(caut),
        .turns_angle(turns_angle), .pwm_half_freq(half), .pwm_err_code(code), .pwm_err_duty(duty));

    iofm_ctrl_model iofm_ctrl_model_i (.hclk(hclk), .clr(clr), .inc_out(inc_out), .inc_oe_n(inc_oe_n),
        .a_edges(a_edges), .min_gap(min_gap));

    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wt;
        repeat (4) @(posedge hclk);
        #1;
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        bus(1'b0, `IOFM_ADDR_PWE, 0);
        chk("pwe_rst", rd, {8'h00, `IOFM_RST_PWE});
        bus(1'b0, `IOFM_ADDR_ABI, 0);
        chk("abi_rst", rd, {8'h00, `IOFM_RST_ABI});
        chk("oe_off", {29'h0, inc_oe_n}, 32'h7);
        chk("hresp", {31'h0, hresp}, 32'h0);
        bus(1'b1, `IOFM_ADDR_MSK, 32'hffffffff);
        bus(1'b0, `IOFM_ADDR_MSK, 0);
        chk("msk_rw", rd, 32'h00ffffff);
        bus(1'b1, 8'h70, 32'h5a5a5a5a);
        bus(1'b0, 8'h70, 0);
        chk("unmapped", rd, 32'h0);
    endtask

    task automatic t_mask;
        for (int i = 0; i < 24; i++) begin
            if (`IOFM_MASKABLE >> i & 1) begin
                bus(1'b1, `IOFM_ADDR_MSK, 0);
                @(posedge hclk);
                err_active <= 24'h1 << i;
                wt();
                chk("agg_on", agg, 1);
                bus(1'b1, `IOFM_ADDR_MSK, 32'h1 << i);
                wt();
                chk("agg_masked", agg, 0);
            end
        end
        bus(1'b1, `IOFM_ADDR_MSK, 0);
        @(posedge hclk);
        err_active <= 24'h008000;
        wt();
        chk("caution_on", caut, 1);
        bus(1'b1, `IOFM_ADDR_MSK, 32'h1 << `IOFM_MSK_WARN);
        wt();
        chk("caution_off", caut, 0);
        chk("agg_kept", agg, 1);
    endtask

    task automatic t_pwm;
        bus(1'b1, `IOFM_ADDR_CTL, 32'h3);
        bus(1'b1, `IOFM_ADDR_PWE, 32'h1800);
        @(posedge hclk);
        pwm_err_src <= 13'h1800;
        wt();
        chk("code_both", code, 12);
        chk("duty_temp", duty, 1070);
        chk("half", half, 1);
        @(posedge hclk);
        pwm_err_src <= 13'h1000;
        wt();
        chk("duty_tov", duty, 1160);
        bus(1'b1, `IOFM_ADDR_PWE, 32'h0800);
        wt();
        chk("code_off", code, 0);
    endtask

    task automatic t_turns;
        logic [10:0] ofs;
        @(posedge hclk);
        zcd_angle <= 12'h100;
        pll_angle <= 12'h123;
        ofs = 11'((12'h123 - 12'h100) >> 1);
        bus(1'b1, `IOFM_ADDR_PWE, 32'(ofs) << `IOFM_PWE_OFS_LO);
        bus(1'b1, `IOFM_ADDR_CTL, 0);
        wt();
        chk("turns_zcd", turns_angle, 12'h122);
        bus(1'b1, `IOFM_ADDR_CTL, 32'h4);
        wt();
        chk("turns_pll", turns_angle, 12'h123);
        @(posedge hclk);
        low_power <= 1'b1;
        wt();
        chk("turns_lpm", turns_angle, 12'h122);
        @(posedge hclk);
        low_power <= 1'b0;
    endtask

    // Config, raw angle, hysteresis angle, lock, watchdog, expected pins
    task automatic quad(input logic [31:0] c, input logic [15:0] a, input logic [15:0] h, input logic l,
                        input logic w, input logic [2:0] e);
        bus(1'b1, `IOFM_ADDR_ABI, c);
        @(posedge hclk);
        angle_raw    <= a;
        angle_hys    <= h;
        pll_locked   <= l;
        hf_wdog_trip <= w;
        wt();
        chk("inc_out", inc_out, e);
    endtask

    task automatic t_quad;
        quad(32'h002d, 16'h0000, 0, 1, 0, 3'b100);
        quad(32'h002d, 16'he000, 0, 1, 0, 3'b010);
        quad(32'h012d, 16'he000, 0, 1, 0, 3'b110);
        quad(32'h022d, 16'h2000, 0, 1, 0, 3'b101);
        quad(32'h022d, 16'hc000, 0, 1, 0, 3'b011);
        quad(32'h032d, 16'hc000, 0, 1, 0, 3'b111);
        chk("oe_on", inc_oe_n, 3'b000);
        quad(32'h102d, 16'h0000, 16'h2000, 1, 0, 3'b001);
        quad(32'h802d, 16'h2000, 0, 1, 0, 3'b110);
        quad(32'h006d, 16'h2000, 0, 0, 0, 3'b111);
        quad(32'h806d, 16'h2000, 0, 0, 0, 3'b000);
        quad(32'h00ad, 16'h2000, 0, 1, 1, 3'b111);
        quad(32'h0031, 16'h2000, 0, 1, 0, 3'b110);
    endtask

    task automatic sweep(input logic [31:0] c);
        quad(c, 0, 0, 1, 0, 3'b100);
        @(posedge hclk);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        for (int k = 1; k <= 16; k++) begin
            @(posedge hclk);
            angle_raw <= 16'(k * 16'h1000);
        end
        repeat (40) @(posedge hclk);
    endtask

    task automatic t_slew;
        sweep(32'h002c);
        chk("a_edges", a_edges, 8);
        chk("gap_free", min_gap, 1);
        sweep(32'h1002c);
        chk("gap_slew", min_gap >= 5, 1);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_mask();
        t_pwm();
        t_turns();
        t_quad();
        t_slew();
        print_verdict();
    end

    initial begin
        #2000000;
        num_errors++;
        print_verdict();
    end
endmodule
